//--- dv/dwa_link_host.sv
// Purpose: Link-side host model that offers requests to the sequencer
// Assumes: 15 ns link clock, running only in transfers and reset
// Notes: A released request word is inverted
`timescale 1ns/1ps
`default_nettype none
module dwa_link_host (
  input wire logic rst, // Reset seen
  input wire logic reqReady, // Request taken
  input wire logic [15:0] rdData, // Read word
  output logic linkClk, // Link clock
  output logic reqValid, // Request offered
  output dwa_pkg::dwa_req_s reqIn, // Request word
  output logic faultSeen, // Fault pulse
  output logic busActive // Transfer open
);
  import dwa_pkg::*;
  logic hold = 1'b0;
  initial begin
    linkClk = 0;
    reqValid = 0;
    reqIn = '0;
    faultSeen = 0;
    busActive = 0;
  end
  // Clock stands low between transfers
  always #7.5 if ((busActive && !hold) || rst || linkClk) linkClk = ~linkClk;
  task automatic xfer(input dwa_kind_e k, input logic g, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    #1 busActive = 1;
    @(posedge linkClk) #1;
    reqValid = 1;
    reqIn = '{k, g, a, d};
    do @(posedge linkClk); while (reqReady !== 1);
    #1 reqValid = 0;
    reqIn = ~reqIn;
    for (int n = 0; n < 40 && reqReady !== 1; n++) @(posedge linkClk) #1;
    q = rdData;
    busActive = 0;
  endtask
  // Transaction left open with the clock stopped
  task automatic stall();
    #1 busActive = 1;
    hold = 1;
    #1000 busActive = 0;
    hold = 0;
  endtask
  task automatic fault_pulse();
    #1 busActive = 1;
    @(posedge linkClk) #1 faultSeen = 1;
    @(posedge linkClk) #1 faultSeen = 0;
    busActive = 0;
  endtask
endmodule // dwa_link_host
`default_nettype wire

//--- dv/dwa_sequencer_test.sv
// Purpose: Register-level tests of the waveform, margin and alarm sequencer
// Assumes: 8 ns core clock, MS_CYC shortened to 20
// Notes: Expected codes follow the programmed limits
`timescale 1ns/1ps
`default_nettype none
module dwa_sequencer_test;
  import dwa_pkg::*;
  logic core_clk = 0, reset = 1, sdaLowReq = 0, reqReady, reqValid, linkClk, faultSeen;
  logic busActive, sdaOe, outputOn, waveformActive, marginActive, alarmActive, rdValid, sdaOut;
  logic [15:0] rdData, q, v;
  logic [9:0] dacCode;
  dwa_req_s reqIn;
  int bad_count = 0, samples_checked = 0, n;
  always #4 core_clk = ~core_clk;
  dwa_link_host u_host (.rst(reset), .reqReady(reqReady), .rdData(rdData), .linkClk(linkClk),
    .reqValid(reqValid), .reqIn(reqIn), .faultSeen(faultSeen), .busActive(busActive));
  dwa_sequencer #(.MS_CYC(20), .TIMEOUT_MS(3), .VERSION(16'h0b17)) u_dut (.core_clk(core_clk),
    .reset(reset), .linkClk(linkClk), .reqValid(reqValid), .reqIn(reqIn), .faultSeen(faultSeen),
    .busActive(busActive), .sdaLowReq(sdaLowReq), .reqReady(reqReady), .rdValid(rdValid),
    .rdData(rdData), .sdaOut(sdaOut), .sdaOe(sdaOe), .dacCode(dacCode), .outputOn(outputOn),
    .waveformActive(waveformActive), .marginActive(marginActive), .alarmActive(alarmActive));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    u_host.xfer(REQ_READ, 1'b0, a, 16'h0000, q);
    check(q, exp);
    check(16'(rdValid), 16'h0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(REQ_WRITE, 1'b0, a, d, q);
    check(16'(rdValid), 16'h0000);
  endtask
  // Cycles until dacCode next changes
  task automatic next_change();
    v = 16'(dacCode);
    for (n = 0; n < 9000 && 16'(dacCode) === v; n++) @(negedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000 bad_count++;
    tally_and_finish();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) reset = 0;
    rd(ADDR_GENERAL, GEN_RESET);
    rd(ADDR_VERSION, 16'h0b17);
    rd(8'h55, 16'h0000);
    $display("registers done");
    wr(ADDR_UPPER, 16'h0070);
    wr(ADDR_LOWER, 16'h0010);
    wr(ADDR_GENERAL, 16'h031e);
    wr(ADDR_TRIGGER, 16'h0001);
    check(16'(waveformActive), 16'h0001);
    next_change();
    next_change();
    check(16'(n), 16'h01f4);
    wr(ADDR_GENERAL, 16'h017e);
    for (int i = 0; i < 5 && 16'(dacCode) !== 16'h0010; i++) next_change();
    next_change();
    check(16'(dacCode), 16'h0030);
    wr(ADDR_GENERAL, 16'h007e);
    for (int i = 0; i < 6 && 16'(dacCode) !== 16'h0070; i++) next_change();
    next_change();
    check(16'(dacCode), 16'h0050);
    wr(ADDR_TRIGGER, 16'h0000);
    $display("waveform done");
    wr(ADDR_OPERATION, 16'ha400);
    check(16'(marginActive), 16'h0000);
    wr(ADDR_GENERAL, 16'h107f);
    wr(ADDR_OPERATION, 16'ha400);
    repeat (20) @(negedge core_clk);
    check(16'(dacCode), 16'h0070);
    wr(ADDR_OPERATION, 16'h9400);
    repeat (20) @(negedge core_clk);
    check(16'(dacCode), 16'h0010);
    wr(ADDR_OPERATION, 16'h0000);
    check(16'(outputOn), 16'h0000);
    wr(ADDR_OPERATION, 16'h8000);
    check(16'(outputOn), 16'h0001);
    u_host.xfer(REQ_WRITE, 1'b1, ADDR_OPERATION, 16'h0000, q);
    check(16'(outputOn), 16'h0001);
    u_host.xfer(REQ_STOP, 1'b0, ADDR_OPERATION, 16'h0000, q);
    check(16'(outputOn), 16'h0000);
    $display("margin done");
    u_host.fault_pulse();
    rd(ADDR_FAULT, 16'h0002);
    wr(ADDR_FAULT, 16'h0002);
    rd(ADDR_FAULT, 16'h0000);
    u_host.stall();
    rd(ADDR_FAULT, 16'h0002);
    wr(ADDR_FAULT, 16'h0002);
    @(negedge core_clk) sdaLowReq = 1;
    rd(ADDR_TRIGGER, 16'h0000);
    #200 check(16'(sdaOe), 16'h0001);
    check(16'(sdaOut), 16'h0000);
    $display("link done");
    wr(ADDR_ALARM, 16'h0500);
    repeat (10) @(negedge core_clk);
    check(16'(dacCode), 16'h0070);
    next_change();
    next_change();
    check(16'(n), 16'h012c);
    next_change();
    check(16'(n), 16'h0640);
    wr(ADDR_ALARM, 16'h0000);
    check(16'(alarmActive), 16'h0001);
    for (int i = 0; i < 20000 && alarmActive === 1; i++) @(negedge core_clk);
    check(16'(alarmActive), 16'h0000);
    $display("alarm done");
    tally_and_finish();
  end
endmodule // dwa_sequencer_test
`default_nettype wire

//--- include/dwa_pkg.sv
// Purpose: Shared constants, types and lookups for the waveform, margin and alarm sequencer
// Assumes: 125 MHz core clock; registers are 16 bits wide
// Notes: Times are kept in their printed units and converted by expression
`default_nettype none
package dwa_pkg;
  localparam int CLK_NS = 8;
  localparam int STEP_UNIT_NS = 400;
  localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC_DEF = MS_NS / CLK_NS;
  localparam int TIMEOUT_MS_DEF = 25;
  // Register offsets
  localparam logic [7:0] ADDR_OPERATION = 8'h01;
  localparam logic [7:0] ADDR_UPPER = 8'h25;
  localparam logic [7:0] ADDR_LOWER = 8'h26;
  localparam logic [7:0] ADDR_FAULT = 8'h78;
  localparam logic [7:0] ADDR_VERSION = 8'h98;
  localparam logic [7:0] ADDR_GENERAL = 8'hd1;
  localparam logic [7:0] ADDR_ALARM = 8'hd2;
  localparam logic [7:0] ADDR_TRIGGER = 8'hd3;
  // Field positions
  localparam int GEN_STEP_LSB = 0;
  localparam int GEN_INC_LSB = 4;
  localparam int GEN_SHAPE_LSB = 8;
  localparam int GEN_PROTO_BIT = 12;
  localparam int ALM_GAP_LSB = 0;
  localparam int ALM_OFF_LSB = 2;
  localparam int ALM_ON_LSB = 4;
  localparam int ALM_LP_BIT = 8;
  localparam int ALM_MP_BIT = 9;
  localparam int ALM_HP_BIT = 10;
  localparam int TRIG_START_BIT = 0;
  localparam int FAULT_BIT = 1;
  localparam int OP_CMD_LSB = 8;
  // Reset values
  localparam logic [15:0] GEN_RESET = 16'h000f;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Operation commands and shapes
  localparam logic [7:0] OP_OFF = 8'h00;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_MARGIN_LOW = 8'h94;
  localparam logic [7:0] OP_MARGIN_HIGH = 8'ha4;
  localparam logic [1:0] SHAPE_TRIANGLE = 2'h0;
  localparam logic [1:0] SHAPE_SAW_UP = 2'h1;
  localparam logic [1:0] SHAPE_SAW_DOWN = 2'h2;
  localparam logic [1:0] SHAPE_SQUARE = 2'h3;
  localparam logic [3:0] STEP_NO_SLEW = 4'hf;
  localparam logic [5:0] INC_CODES [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};
  localparam int STEP_BASE_NS [3] = '{25600, 204800, 1638400};
  localparam int STEP_FAST_NS [4] = '{12000, 8000, 4000, STEP_UNIT_NS};
  localparam int HP_GAP_MS [4] = '{2550, 2960, 3380, 3800};
  localparam int MP_GAP_MS [4] = '{2600, 3060, 3520, 4000};
  localparam int LP_GAP_MS = 16000;
  localparam int HP_OFF_MS [4] = '{15, 36, 58, 80};
  localparam int ML_OFF_MS [4] = '{40, 60, 80, 100};
  localparam int HP_ON_MS [4] = '{80, 103, 126, 150};
  localparam int ML_ON_MS [4] = '{130, 153, 176, 200};

  typedef enum logic [1:0] {REQ_WRITE, REQ_READ, REQ_STOP} dwa_kind_e;
  typedef enum logic [1:0] {PR_LOW, PR_MED, PR_HIGH} dwa_prio_e;
  typedef enum logic [1:0] {AL_IDLE, AL_ON, AL_OFF, AL_GAP} dwa_alarm_e;
  typedef struct packed {
    dwa_kind_e kind;
    logic group;
    logic [7:0] addr;
    logic [15:0] data;
  } dwa_req_s;

  // Step period in 0.4 us units
  function automatic logic [12:0] step_units(input logic [3:0] code);
    int ns;
    if (code[3:2] != 2'h3) ns = STEP_BASE_NS[code[3:2]] * (4 + int'(code[1:0])) / 4;
    else ns = STEP_FAST_NS[code[1:0]];
    return 13'(ns / STEP_UNIT_NS);
  endfunction

  // Duration of the current alarm phase in ms
  function automatic logic [13:0] alarm_ms(input dwa_alarm_e st, input dwa_prio_e pr,
                                           input logic [5:0] sel);
    int ms;
    ms = 1;
    unique case (st)
      AL_ON: ms = (pr == PR_HIGH) ? HP_ON_MS[sel[5:4]] : ML_ON_MS[sel[5:4]];
      AL_OFF: ms = (pr == PR_HIGH) ? HP_OFF_MS[sel[3:2]] : ML_OFF_MS[sel[3:2]];
      AL_GAP: ms = (pr == PR_HIGH) ? HP_GAP_MS[sel[1:0]] :
                   (pr == PR_MED) ? MP_GAP_MS[sel[1:0]] : LP_GAP_MS;
      AL_IDLE: ms = 1;
    endcase
    return 14'(ms);
  endfunction
endpackage
`default_nettype wire

//--- logic/dwa_sequencer.sv
// Purpose: Waveform, margin and alarm code sequencer with link-side register port
// Assumes: A serial engine on linkClk hands over requests; SCL is linkClk
// Notes: dacCode is the converter code; analog side lies outside
// Function
// - Start bit launches continuous waveform mode
// - Shape 00 gives paced triangle between limits
// - Shape 01 ramps up, jumps to lower
// - Shape 10 ramps down, jumps to upper
// - Shape 11 alternates upper and lower per step
// - Ramps move by increment each step period
// - Operation commands act only when protocol enabled
// - Operation upper byte selects off, on, margins
// - Margins ramp toward limit code at pace
// - Group commands and link time-out detection
// - Bus fault flag sets, host clears by one
// - Data line held low until next clock
// - Version register returns protocol version
// - Alarm bit starts repeating burst generation
// - Cleared alarm finishes current burst first
// - Interburst gap per priority, and per code for high and medium
// - Pulse low time per priority and code
// - Pulse high time per priority and code
// - Increment field selects codes per step
// - Step field selects period or no stepping
`timescale 1ns/1ps
`default_nettype none
module dwa_sequencer #(
  parameter int CODE_W = 10,
  parameter int MS_CYC = dwa_pkg::MS_CYC_DEF,
  parameter int TIMEOUT_MS = dwa_pkg::TIMEOUT_MS_DEF,
  parameter int PULSES_HP = 10,
  parameter int PULSES_MP = 3,
  parameter int PULSES_LP = 2,
  parameter logic [15:0] VERSION = 16'h0022
) (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic linkClk, // Link clock
  input wire logic reqValid, // Request offered
  input wire dwa_pkg::dwa_req_s reqIn, // Request word
  input wire logic faultSeen, // Bus fault pulse
  input wire logic busActive, // Transaction in progress
  input wire logic sdaLowReq, // Engine wants data line low
  output var logic reqReady, // Request accepted
  output var logic rdValid, // Read data pulse
  output var logic [15:0] rdData, // Read data
  output var logic sdaOut, // Data line out
  output var logic sdaOe, // Data line enable
  output var logic [CODE_W-1:0] dacCode, // Output code
  output var logic outputOn, // Output turned on
  output var logic waveformActive, // Waveform running
  output var logic marginActive, // Margin in force
  output var logic alarmActive // Alarm running
);
  import dwa_pkg::*;
  localparam int MS_W = $clog2(MS_CYC + 1);
  localparam int UNIT_W = $clog2(STEP_UNIT_CYC + 1);

  // ==========================================================
  // Link domain
  dwa_req_s reqHold_reg;
  logic reqTgl_reg, reqReady_reg, rdValid_reg, faultTgl_reg, actTgl_reg;
  logic ackS1_reg, ackS2_reg, ackS3_reg, sdaOe_reg, sdaOut_reg, ackTgl_reg;
  logic [15:0] rdData_reg, rdWord_reg;
  wire reqTake = reqValid && reqReady_reg;
  wire ackEdge = ackS2_reg ^ ackS3_reg;
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      reqHold_reg <= '0;
      reqTgl_reg <= 1'b0;
    end else if (reqTake) begin
      reqHold_reg <= reqIn;
      reqTgl_reg <= ~reqTgl_reg;
    end
  end
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      {ackS1_reg, ackS2_reg, ackS3_reg} <= 3'h0;
      reqReady_reg <= 1'b1;
      rdValid_reg <= 1'b0;
      rdData_reg <= WORD_RESET;
    end else begin
      {ackS1_reg, ackS2_reg, ackS3_reg} <= {ackTgl_reg, ackS1_reg, ackS2_reg};
      reqReady_reg <= reqTake ? 1'b0 : (ackEdge ? 1'b1 : reqReady_reg);
      rdValid_reg <= ackEdge && (reqHold_reg.kind == REQ_READ);
      rdData_reg <= ackEdge ? rdWord_reg : rdData_reg;
    end
  end
  // Enable changes only on a link edge, so a low data line stands through a time-out
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      {faultTgl_reg, actTgl_reg, sdaOe_reg, sdaOut_reg} <= 4'h0;
    end else begin
      faultTgl_reg <= faultTgl_reg ^ faultSeen;
      actTgl_reg <= actTgl_reg ^ busActive;
      sdaOe_reg <= sdaLowReq;
      sdaOut_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Crossings into the core domain
  logic [2:0] reqS_reg, faultS_reg, actS_reg;
  logic [1:0] busS_reg;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {reqS_reg, faultS_reg, actS_reg} <= 9'h000;
      busS_reg <= 2'h0;
    end else begin
      reqS_reg <= {reqS_reg[1:0], reqTgl_reg};
      faultS_reg <= {faultS_reg[1:0], faultTgl_reg};
      actS_reg <= {actS_reg[1:0], actTgl_reg};
      busS_reg <= {busS_reg[0], busActive};
    end
  end
  wire reqEdge = reqS_reg[1] ^ reqS_reg[2];
  wire faultEdge = faultS_reg[1] ^ faultS_reg[2];
  wire actEdge = actS_reg[1] ^ actS_reg[2];

  // ==========================================================
  // Registers and decode
  logic [15:0] opCmd_reg, upper_reg, lower_reg, genSet_reg, alarmSet_reg, groupCmd_reg;
  logic trigStart_reg, fault_reg, groupPend_reg;
  wire wrHit = reqEdge && (reqHold_reg.kind == REQ_WRITE);
  wire rdHit = reqEdge && (reqHold_reg.kind == REQ_READ);
  wire stopHit = reqEdge && (reqHold_reg.kind == REQ_STOP);
  wire [7:0] addr = reqHold_reg.addr;
  wire [15:0] wdata = reqHold_reg.data;
  wire wrOp = wrHit && (addr == ADDR_OPERATION);
  wire protoEn = genSet_reg[GEN_PROTO_BIT];
  wire opNow = wrOp && !reqHold_reg.group;
  wire opFromGroup = stopHit && groupPend_reg;
  wire opRaw = opNow || opFromGroup;
  wire opFire = opRaw && protoEn;
  wire [7:0] opValue = opNow ? wdata[15:8] : groupCmd_reg[15:8];
  wire faultClear = wrHit && (addr == ADDR_FAULT) && wdata[FAULT_BIT];
  logic timeoutHit;
  wire faultSet = faultEdge || timeoutHit;
  wire [15:0] rdMux =
    (addr == ADDR_OPERATION) ? opCmd_reg :
    (addr == ADDR_UPPER) ? upper_reg :
    (addr == ADDR_LOWER) ? lower_reg :
    (addr == ADDR_FAULT) ? (16'(fault_reg) << FAULT_BIT) :
    (addr == ADDR_VERSION) ? VERSION :
    (addr == ADDR_GENERAL) ? genSet_reg :
    (addr == ADDR_ALARM) ? alarmSet_reg :
    (addr == ADDR_TRIGGER) ? (16'(trigStart_reg) << TRIG_START_BIT) : WORD_RESET;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {opCmd_reg, upper_reg, lower_reg, alarmSet_reg} <= {4{WORD_RESET}};
      genSet_reg <= GEN_RESET;
      trigStart_reg <= 1'b0;
    end else if (wrHit) begin
      if (addr == ADDR_OPERATION) opCmd_reg <= wdata;
      if (addr == ADDR_UPPER) upper_reg <= wdata;
      if (addr == ADDR_LOWER) lower_reg <= wdata;
      if (addr == ADDR_GENERAL) genSet_reg <= wdata;
      if (addr == ADDR_ALARM) alarmSet_reg <= wdata;
      if (addr == ADDR_TRIGGER) trigStart_reg <= wdata[TRIG_START_BIT];
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {fault_reg, groupPend_reg, ackTgl_reg} <= 3'h0;
      groupCmd_reg <= WORD_RESET;
      rdWord_reg <= WORD_RESET;
    end else begin
      fault_reg <= faultSet ? 1'b1 : (faultClear ? 1'b0 : fault_reg);
      groupPend_reg <= (wrOp && reqHold_reg.group) ? 1'b1 : (stopHit ? 1'b0 : groupPend_reg);
      groupCmd_reg <= (wrOp && reqHold_reg.group) ? wdata : groupCmd_reg;
      rdWord_reg <= rdHit ? rdMux : rdWord_reg;
      ackTgl_reg <= ackTgl_reg ^ reqEdge;
    end
  end

  // ==========================================================
  // Timebases and link time-out
  logic [UNIT_W-1:0] unitCnt_reg;
  logic [12:0] stepCnt_reg;
  logic [MS_W-1:0] msCnt_reg;
  logic [15:0] idleMs_reg;
  wire [3:0] stepCode = genSet_reg[GEN_STEP_LSB +: 4];
  wire noSlew = (stepCode == STEP_NO_SLEW);
  wire [12:0] stepLen = step_units(stepCode);
  wire unitTick = (unitCnt_reg == UNIT_W'(STEP_UNIT_CYC - 1));
  wire stepTick = noSlew || (unitTick && (stepCnt_reg >= stepLen - 13'd1));
  wire msTick = (msCnt_reg == MS_W'(MS_CYC - 1));
  wire idleLast = (idleMs_reg == 16'(TIMEOUT_MS - 1));
  assign timeoutHit = msTick && busS_reg[1] && !actEdge && idleLast;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      unitCnt_reg <= '0;
      stepCnt_reg <= '0;
      msCnt_reg <= '0;
    end else begin
      unitCnt_reg <= unitTick ? '0 : unitCnt_reg + UNIT_W'(1);
      stepCnt_reg <= stepTick ? '0 : (unitTick ? stepCnt_reg + 13'd1 : stepCnt_reg);
      msCnt_reg <= msTick ? '0 : msCnt_reg + MS_W'(1);
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) idleMs_reg <= '0;
    else if (!busS_reg[1] || actEdge) idleMs_reg <= '0;
    else if (msTick && (idleMs_reg != 16'(TIMEOUT_MS))) idleMs_reg <= idleMs_reg + 16'd1;
  end

  // ==========================================================
  // Alarm burst sequencer
  dwa_alarm_e alState_reg, alState_next;
  dwa_prio_e prio_reg;
  logic [13:0] alTimer_reg;
  logic [4:0] pulseCnt_reg;
  logic alToUpper, alToLower;
  wire alHp = alarmSet_reg[ALM_HP_BIT];
  wire alMp = alarmSet_reg[ALM_MP_BIT];
  wire alarmReq = alHp || alMp || alarmSet_reg[ALM_LP_BIT];
  wire dwa_prio_e topPrio = alHp ? PR_HIGH : (alMp ? PR_MED : PR_LOW);
  wire [13:0] alarmDur = alarm_ms(alState_reg, prio_reg, alarmSet_reg[5:0]);
  wire alarmDone = msTick && (alTimer_reg >= alarmDur - 14'd1);
  wire [4:0] pulsesNeeded = (prio_reg == PR_HIGH) ? 5'(PULSES_HP) :
                            (prio_reg == PR_MED) ? 5'(PULSES_MP) : 5'(PULSES_LP);
  wire lastPulse = (pulseCnt_reg >= pulsesNeeded - 5'd1);
  wire alIdle = (alState_reg == AL_IDLE);
  always_comb begin
    alState_next = alState_reg;
    alToUpper = 1'b0;
    alToLower = 1'b0;
    unique case (alState_reg)
      AL_IDLE: if (alarmReq) begin
        alState_next = AL_ON;
        alToUpper = 1'b1;
      end
      AL_ON: if (alarmDone) begin
        alState_next = AL_OFF;
        alToLower = 1'b1;
      end
      AL_OFF: if (alarmDone) begin
        alState_next = !lastPulse ? AL_ON : (alarmReq ? AL_GAP : AL_IDLE);
        alToUpper = !lastPulse;
      end
      AL_GAP: if (alarmDone) begin
        alState_next = alarmReq ? AL_ON : AL_IDLE;
        alToUpper = alarmReq;
      end
    endcase
  end
  wire burstStart = alToUpper && (alState_reg != AL_OFF);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      alState_reg <= AL_IDLE;
      prio_reg <= PR_LOW;
      alTimer_reg <= '0;
      pulseCnt_reg <= '0;
    end else begin
      alState_reg <= alState_next;
      prio_reg <= burstStart ? topPrio : prio_reg;
      alTimer_reg <= (alState_next != alState_reg) ? '0 : alTimer_reg + 14'(msTick);
      pulseCnt_reg <= burstStart ? '0 : pulseCnt_reg + 5'(alToUpper);
    end
  end

  // ==========================================================
  // Code generator
  logic [CODE_W-1:0] dacCode_reg, code_next;
  logic dirUp_reg, dirUp_next, outputOn_reg, marginActive_reg, marginHigh_reg;
  logic waveformActive_reg, alarmActive_reg;
  wire [CODE_W-1:0] upperCode = upper_reg[CODE_W-1:0];
  wire [CODE_W-1:0] lowerCode = lower_reg[CODE_W-1:0];
  wire [CODE_W-1:0] marginTarget = marginHigh_reg ? upperCode : lowerCode;
  wire [1:0] shape = genSet_reg[GEN_SHAPE_LSB +: 2];
  wire [CODE_W-1:0] inc = noSlew ? '1 : CODE_W'(INC_CODES[genSet_reg[GEN_INC_LSB +: 3]]);
  wire waveRun = trigStart_reg && alIdle;
  wire waveStart = waveRun && !waveformActive_reg;
  wire [CODE_W-1:0] triTarget = dirUp_reg ? upperCode : lowerCode;

  function automatic logic [CODE_W-1:0] toward(input logic [CODE_W-1:0] cur,
      input logic [CODE_W-1:0] tgt, input logic [CODE_W-1:0] stp);
    logic [CODE_W:0] upSum;
    upSum = {1'b0, cur} + {1'b0, stp};
    if (cur < tgt) toward = (upSum >= {1'b0, tgt}) ? tgt : upSum[CODE_W-1:0];
    else if (cur - tgt > stp) toward = cur - stp;
    else toward = tgt;
  endfunction

  always_comb begin
    code_next = dacCode_reg;
    dirUp_next = dirUp_reg;
    if (alToUpper) code_next = upperCode;
    else if (alToLower) code_next = lowerCode;
    else if (!alIdle) code_next = dacCode_reg;
    else if (waveStart) begin
      code_next = lowerCode;
      dirUp_next = 1'b1;
    end else if (waveRun && stepTick) begin
      unique case (shape)
        SHAPE_TRIANGLE: begin
          dirUp_next = (dacCode_reg == triTarget) ? !dirUp_reg : dirUp_reg;
          code_next = toward(dacCode_reg, dirUp_next ? upperCode : lowerCode, inc);
        end
        SHAPE_SAW_UP: code_next = (dacCode_reg == upperCode) ? lowerCode :
                                  toward(dacCode_reg, upperCode, inc);
        SHAPE_SAW_DOWN: code_next = (dacCode_reg == lowerCode) ? upperCode :
                                    toward(dacCode_reg, lowerCode, inc);
        SHAPE_SQUARE: begin
          code_next = (dacCode_reg == upperCode) ? lowerCode : upperCode;
          dirUp_next = !dirUp_reg;
        end
      endcase
    end else if (!waveRun && marginActive_reg && stepTick) begin
      code_next = toward(dacCode_reg, marginTarget, inc);
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dacCode_reg <= '0;
      {dirUp_reg, waveformActive_reg, alarmActive_reg} <= 3'h0;
    end else begin
      dacCode_reg <= code_next;
      dirUp_reg <= dirUp_next;
      waveformActive_reg <= waveRun;
      alarmActive_reg <= (alState_next != AL_IDLE);
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {outputOn_reg, marginActive_reg, marginHigh_reg} <= 3'h0;
    end else if (opFire) begin
      outputOn_reg <= (opValue != OP_OFF) ? 1'b1 : 1'b0;
      marginActive_reg <= (opValue == OP_MARGIN_LOW) || (opValue == OP_MARGIN_HIGH);
      marginHigh_reg <= (opValue == OP_MARGIN_HIGH);
    end
  end

  assign reqReady = reqReady_reg;
  assign rdValid = rdValid_reg;
  assign rdData = rdData_reg;
  assign sdaOut = sdaOut_reg;
  assign sdaOe = sdaOe_reg;
  assign dacCode = dacCode_reg;
  assign outputOn = outputOn_reg;
  assign waveformActive = waveformActive_reg;
  assign marginActive = marginActive_reg;
  assign alarmActive = alarmActive_reg;

  // ==========================================================
  // Checks
  wire waveGo = waveRun && waveformActive_reg && stepTick && !alarmReq;
  startWave_a: assert property (@(posedge core_clk) disable iff (reset)
    trigStart_reg && alIdle && !alarmReq |=> waveformActive_reg)
    else $error("waveform did not start");
  rampStep_a: assert property (@(posedge core_clk) disable iff (reset)
    waveGo && !noSlew && (shape == SHAPE_SAW_UP || (shape == SHAPE_TRIANGLE && dirUp_reg))
    && dacCode_reg < upperCode
    && (upperCode - dacCode_reg) > inc && !wrHit
    |=> dacCode_reg == $past(dacCode_reg) + $past(inc))
    else $error("ramp step size wrong");
  sawUpWrap_a: assert property (@(posedge core_clk) disable iff (reset)
    waveGo && shape == SHAPE_SAW_UP && dacCode_reg == upperCode |=> dacCode_reg == $past(lowerCode))
    else $error("rising sawtooth did not return");
  sawDownWrap_a: assert property (@(posedge core_clk) disable iff (reset)
    waveGo && shape == SHAPE_SAW_DOWN && dacCode_reg == lowerCode
    |=> dacCode_reg == $past(upperCode))
    else $error("falling sawtooth did not return");
  squareSwap_a: assert property (@(posedge core_clk) disable iff (reset)
    waveGo && shape == SHAPE_SQUARE && !wrHit
    |=> dacCode_reg != $past(dacCode_reg) || upperCode == lowerCode)
    else $error("square wave did not alternate");
  protoGate_a: assert property (@(posedge core_clk) disable iff (reset)
    opRaw && !protoEn |=> $stable(outputOn_reg) && $stable(marginActive_reg))
    else $error("operation acted while disabled");
  opOff_a: assert property (@(posedge core_clk) disable iff (reset)
    opFire && opValue == OP_OFF |=> !outputOn_reg && !marginActive_reg)
    else $error("turn off not applied");
  faultWins_a: assert property (@(posedge core_clk) disable iff (reset)
    faultSet |=> fault_reg)
    else $error("fault flag lost");
  timeoutFlag_a: assert property (@(posedge core_clk) disable iff (reset)
    busS_reg[1] && idleLast && msTick && !actEdge ##1 !faultClear |-> ##1 fault_reg)
    else $error("time-out not flagged");
  versionRead_a: assert property (@(posedge core_clk) disable iff (reset)
    rdHit && addr == ADDR_VERSION |=> rdWord_reg == VERSION)
    else $error("version readback wrong");
  alarmBegin_a: assert property (@(posedge core_clk) disable iff (reset)
    alIdle && alarmReq |=> alState_reg == AL_ON && alarmActive_reg && dacCode_reg == $past(upperCode))
    else $error("alarm did not start");
  burstFinish_a: assert property (@(posedge core_clk) disable iff (reset)
    alState_reg == AL_ON |=> alState_reg != AL_IDLE)
    else $error("burst cut short");
  gapHold_a: assert property (@(posedge core_clk) disable iff (reset)
    alState_reg == AL_GAP && !alarmDone |=> alState_reg == AL_GAP)
    else $error("interburst gap ended early");
  prioPick_a: assert property (@(posedge core_clk) disable iff (reset)
    alIdle && alHp |=> prio_reg == PR_HIGH)
    else $error("wrong alarm priority");
  sdaHold_a: assert property (@(posedge linkClk) disable iff (reset)
    sdaOe_reg && sdaLowReq |=> sdaOe_reg)
    else $error("data line released early");
  gapSeen_c: cover property (@(posedge core_clk) disable iff (reset)
    alState_reg == AL_OFF ##1 alState_reg == AL_GAP);
  triFlip_c: cover property (@(posedge core_clk) disable iff (reset)
    waveGo && shape == SHAPE_TRIANGLE && dacCode_reg == upperCode && dirUp_reg);
  timeout_c: cover property (@(posedge core_clk) disable iff (reset) timeoutHit);
  groupApply_c: cover property (@(posedge core_clk) disable iff (reset) opFromGroup && protoEn);
endmodule // dwa_sequencer
`default_nettype wire
